// [design/cap_table_jump_regs.vh]
// constants shared by the table-jump unit and its entry-range helper
// What this block does
// - integer jump-table CSR is kept and aliases the capability CSR address half
// - jump-table capability CSR is capability wide: metadata high, address low
// - table entry reads are authorised by the jump-table capability only
// - index 32 or more means jump with link, below 32 plain jump
// - entry address is CSR address plus index times register bytes; entry is target
// - every entry byte is checked against jump-table capability bounds, not pc bounds
// - jump needs capability tagged, unsealed and execute permitted, else fault
// - whole entry must sit inside bounds; partial overlap is a bounds failure
// - link goes to capability return register in capability mode, integer otherwise
// - failed check raises capability fault typed as instruction access fault
// - fault cause is tag, seal, permission or length violation
// - table jumps may decode as illegal while the hart is in debug mode
// - capability-mode forms need compressed, pure-capability and table-jump extensions
// - legacy-mode forms need compressed, legacy-capability and table-jump extensions
// - accessible entry range is precomputed on each jump-table capability write
// - entries stay integer addresses, so entry size stays the register width
`ifndef CAP_TABLE_JUMP_REGS_VH
`define CAP_TABLE_JUMP_REGS_VH

// instruction encoding fields
`define JT_OP_HI 3'h5
`define JT_OP_MID 3'h0
`define JT_OP_LO 2'h2
`define JT_LINK_MIN 8'h20
`define JT_LINK_STEP 2

// metadata bit positions inside the upper half of the capability CSR
`define JT_META_PERM_X 0
`define JT_META_SEALED 1

// fault reporting
`define JT_TYPE_INSN_ACCESS 4'h1
`define JT_CAUSE_NONE 4'h0
`define JT_CAUSE_TAG 4'h1
`define JT_CAUSE_SEAL 4'h2
`define JT_CAUSE_PERM 4'h3
`define JT_CAUSE_LENGTH 4'h4

// sequencer states
`define JT_ST_IDLE 2'h0
`define JT_ST_FETCH 2'h1
`define JT_ST_WAIT 2'h2

// entry index limit (8-bit index gives 256 entries)
`define JT_IDX_COUNT 256

`endif

// [design/jvt_range_calc.v]
// precomputes the range of fully in-bounds table entries on each jump-table capability write
`timescale 1ns/1ns
`include "cap_table_jump_regs.vh"
module jvt_range_calc #(
  parameter XLEN = 32
) (
  input wire clock_i,
  input wire rst_i,
  input wire load_i,
  input wire [XLEN-1:0] addr_i,
  input wire [XLEN:0] base_i,
  input wire [XLEN:0] top_i,
  output reg [8:0] lo_idx_o,
  output reg [8:0] hi_cnt_o
);
  localparam SH = $clog2(XLEN/8);
  localparam [XLEN:0] ROUND = XLEN/8 - 1;
  localparam [XLEN:0] LIMIT = `JT_IDX_COUNT;

  wire [XLEN:0] addr_ext = {1'b0, addr_i};
  wire [XLEN:0] lo_off = (base_i > addr_ext) ? base_i - addr_ext : {(XLEN+1){1'b0}};
  wire [XLEN:0] hi_off = (top_i > addr_ext) ? top_i - addr_ext : {(XLEN+1){1'b0}};
  // lowest index starts at or above base; count of entries whose last byte is below top
  wire [XLEN:0] lo_raw = (lo_off + ROUND) >> SH;
  wire [XLEN:0] hi_raw = hi_off >> SH;
  wire [8:0] lo_d = (lo_raw > LIMIT) ? 9'h100 : lo_raw[8:0];
  wire [8:0] hi_d = (hi_raw > LIMIT) ? 9'h100 : hi_raw[8:0];

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lo_idx_o <= 9'h100;
      hi_cnt_o <= 9'h000;
    end else if (load_i) begin
      lo_idx_o <= lo_d;
      hi_cnt_o <= hi_d;
    end
  end
endmodule // jvt_range_calc

// [design/cap_table_jump_unit.v]
// compressed table-jump decode, capability checks, table fetch, link and redirect
`timescale 1ns/1ns
`include "cap_table_jump_regs.vh"
module cap_table_jump_unit #(
  parameter XLEN = 32,
  parameter HAS_C = 1,
  parameter HAS_PURECAP = 1,
  parameter HAS_LEGACY = 1,
  parameter HAS_ZCMT = 1,
  parameter DEBUG_ILLEGAL = 1
) (
  input wire clock_i,
  input wire rst_i,
  // instruction side
  input wire instr_valid_i,
  input wire [15:0] instr_i,
  input wire [XLEN-1:0] pc_i,
  input wire cap_mode_i,
  input wire debug_mode_i,
  output wire ready_o,
  output wire accept_o,
  // jump-table capability CSR writes
  input wire jvtc_we_i,
  input wire [2*XLEN-1:0] jvtc_wdata_i,
  input wire jvtc_wtag_i,
  input wire [XLEN:0] jvtc_wbase_i,
  input wire [XLEN:0] jvtc_wtop_i,
  input wire jvt_we_i,
  input wire [XLEN-1:0] jvt_wdata_i,
  // CSR reads
  output wire [XLEN-1:0] jvt_rdata_o,
  output wire [2*XLEN-1:0] jvtc_rdata_o,
  output wire jvtc_tag_o,
  // table entry fetch
  output wire fetch_req_o,
  output reg [XLEN-1:0] fetch_addr_o,
  input wire fetch_gnt_i,
  input wire fetch_rvalid_i,
  input wire [XLEN-1:0] fetch_rdata_i,
  // results
  output reg redirect_o,
  output reg [XLEN-1:0] redirect_pc_o,
  output reg link_we_o,
  output reg link_cap_o,
  output reg [XLEN-1:0] link_data_o,
  output reg illegal_o,
  output reg fault_o,
  output reg [3:0] fault_type_o,
  output reg [3:0] fault_cause_o,
  output reg [XLEN-1:0] fault_addr_o
);
  localparam SH = $clog2(XLEN/8);
  localparam [XLEN-1:0] LINK_STEP = `JT_LINK_STEP;
  localparam CAP_OK = (HAS_C != 0) && (HAS_PURECAP != 0) && (HAS_ZCMT != 0);
  localparam LEG_OK = (HAS_C != 0) && (HAS_LEGACY != 0) && (HAS_ZCMT != 0);
  localparam [1:0] ST_IDLE = `JT_ST_IDLE;
  localparam [1:0] ST_FETCH = `JT_ST_FETCH;
  localparam [1:0] ST_WAIT = `JT_ST_WAIT;

  ////////////////////////////////////////////////////////////////////////////////
  // jump-table capability CSR

  reg [2*XLEN-1:0] jvtc_q;
  reg jvtc_tag_q;
  reg [XLEN:0] jvtc_base_q;
  reg [XLEN:0] jvtc_top_q;
  wire [8:0] range_lo;
  wire [8:0] range_hi;

  // integer alias only replaces the address half; metadata and bounds stay
  wire [2*XLEN-1:0] jvtc_d = jvtc_we_i ? jvtc_wdata_i :
                             {jvtc_q[2*XLEN-1:XLEN], jvt_wdata_i};
  wire jvtc_load = jvtc_we_i | jvt_we_i;
  wire [XLEN:0] base_d = jvtc_we_i ? jvtc_wbase_i : jvtc_base_q;
  wire [XLEN:0] top_d = jvtc_we_i ? jvtc_wtop_i : jvtc_top_q;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      jvtc_q <= {(2*XLEN){1'b0}};
      jvtc_tag_q <= 1'b0;
      jvtc_base_q <= {(XLEN+1){1'b0}};
      jvtc_top_q <= {(XLEN+1){1'b0}};
    end else begin
      if (jvtc_load) begin
        jvtc_q <= jvtc_d;
      end
      if (jvtc_we_i) begin
        jvtc_tag_q <= jvtc_wtag_i;
        jvtc_base_q <= jvtc_wbase_i;
        jvtc_top_q <= jvtc_wtop_i;
      end
    end
  end

  assign jvt_rdata_o = jvtc_q[XLEN-1:0];
  assign jvtc_rdata_o = jvtc_q;
  assign jvtc_tag_o = jvtc_tag_q;

  // range follows the same edge as the CSR, so both always agree
  jvt_range_calc #(
    .XLEN(XLEN)
  ) u_range (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .load_i(jvtc_load),
    .addr_i(jvtc_d[XLEN-1:0]),
    .base_i(base_d),
    .top_i(top_d),
    .lo_idx_o(range_lo),
    .hi_cnt_o(range_hi)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode and checks

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg link_pend_q;
  reg link_cap_q;
  reg [XLEN-1:0] link_val_q;

  wire idle = (state_q == ST_IDLE);
  wire [7:0] index = instr_i[9:2];
  wire is_jt = (instr_i[15:13] == `JT_OP_HI) && (instr_i[12:10] == `JT_OP_MID) &&
               (instr_i[1:0] == `JT_OP_LO);
  wire want_link = (index >= `JT_LINK_MIN);
  wire mode_ok = cap_mode_i ? CAP_OK : LEG_OK;
  wire dbg_block = (DEBUG_ILLEGAL != 0) && debug_mode_i;
  wire decode_illegal = !mode_ok || dbg_block;

  // entry size stays the register width in both modes
  wire [XLEN-1:0] index_off = {{(XLEN-8){1'b0}}, index} << SH;
  wire [XLEN-1:0] entry_addr = jvtc_q[XLEN-1:0] + index_off;

  // only jvtc authorises the read; pc capability is never consulted
  wire chk_tag = jvtc_tag_q;
  wire chk_seal = !jvtc_q[XLEN + `JT_META_SEALED];
  wire chk_perm = jvtc_q[XLEN + `JT_META_PERM_X];
  wire [8:0] idx9 = {1'b0, index};
  wire chk_len = (idx9 >= range_lo) && (idx9 < range_hi);

  reg [3:0] cause;
  always @* begin
    cause = `JT_CAUSE_NONE;
    if (!chk_tag) begin
      cause = `JT_CAUSE_TAG;
    end else if (!chk_seal) begin
      cause = `JT_CAUSE_SEAL;
    end else if (!chk_perm) begin
      cause = `JT_CAUSE_PERM;
    end else if (!chk_len) begin
      cause = `JT_CAUSE_LENGTH;
    end
  end

  assign ready_o = idle;
  assign accept_o = instr_valid_i && is_jt && idle;
  wire start_ok = accept_o && !decode_illegal && (cause == `JT_CAUSE_NONE);

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_ok) begin
          state_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (fetch_gnt_i) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (fetch_rvalid_i) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  assign fetch_req_o = (state_q == ST_FETCH);

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      link_pend_q <= 1'b0;
      link_cap_q <= 1'b0;
      link_val_q <= {XLEN{1'b0}};
      fetch_addr_o <= {XLEN{1'b0}};
      redirect_o <= 1'b0;
      redirect_pc_o <= {XLEN{1'b0}};
      link_we_o <= 1'b0;
      link_cap_o <= 1'b0;
      link_data_o <= {XLEN{1'b0}};
      illegal_o <= 1'b0;
      fault_o <= 1'b0;
      fault_type_o <= 4'h0;
      fault_cause_o <= 4'h0;
      fault_addr_o <= {XLEN{1'b0}};
    end else begin
      state_q <= state_d;
      redirect_o <= 1'b0;
      link_we_o <= 1'b0;
      illegal_o <= 1'b0;
      fault_o <= 1'b0;
      if (accept_o) begin
        if (decode_illegal) begin
          illegal_o <= 1'b1;
        end else if (cause != `JT_CAUSE_NONE) begin
          // trap only: no fetch, no link, no redirect
          fault_o <= 1'b1;
          fault_type_o <= `JT_TYPE_INSN_ACCESS;
          fault_cause_o <= cause;
          fault_addr_o <= entry_addr;
        end else begin
          fetch_addr_o <= entry_addr;
          link_pend_q <= want_link;
          link_cap_q <= cap_mode_i;
          link_val_q <= pc_i + LINK_STEP;
        end
      end
      if ((state_q == ST_WAIT) && fetch_rvalid_i) begin
        redirect_o <= 1'b1;
        redirect_pc_o <= fetch_rdata_i;
        link_we_o <= link_pend_q;
        link_cap_o <= link_cap_q;
        link_data_o <= link_val_q;
      end
    end
  end
endmodule // cap_table_jump_unit

// [verif/fetch_partner.sv]
// fetch path model answering table entry reads
`timescale 1ns/1ns
module fetch_partner (
  input wire clock_i,
  input wire rst_i,
  input wire slow_i,
  input wire req_i,
  input wire [31:0] addr_i,
  output wire gnt_o,
  output wire rvalid_o,
  output reg [31:0] rdata_o
);
  reg tick_q;
  reg pend_q;
  // slow mode grants only every other cycle
  assign gnt_o = req_i & (~slow_i | tick_q);
  assign rvalid_o = pend_q;
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tick_q <= 1'b0;
      pend_q <= 1'b0;
      rdata_o <= 32'h0;
    end else begin
      tick_q <= ~tick_q;
      pend_q <= gnt_o;
      // inverted each cycle outside the answer cycle, so the last entry reappears every other cycle
      rdata_o <= gnt_o ? {addr_i[15:0], 16'hC0DE} : ~rdata_o;
    end
  end
endmodule // fetch_partner

// [verif/cap_table_jump_unit_chk.sv]
// port checks for the table-jump unit
`timescale 1ns/1ns
module cap_table_jump_unit_chk #(
  parameter XLEN = 32
) (
  input wire clock_i,
  input wire rst_i,
  input wire accept_o,
  input wire [15:0] instr_i,
  input wire cap_mode_i,
  input wire debug_mode_i,
  input wire jvt_we_i,
  input wire jvtc_we_i,
  input wire [XLEN-1:0] jvt_wdata_i,
  input wire [XLEN-1:0] jvt_rdata_o,
  input wire [2*XLEN-1:0] jvtc_rdata_o,
  input wire fetch_req_o,
  input wire [XLEN-1:0] fetch_addr_o,
  input wire fetch_rvalid_i,
  input wire [XLEN-1:0] fetch_rdata_i,
  input wire redirect_o,
  input wire [XLEN-1:0] redirect_pc_o,
  input wire link_we_o,
  input wire link_cap_o,
  input wire illegal_o,
  input wire fault_o,
  input wire [3:0] fault_type_o,
  input wire [3:0] fault_cause_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  reg [7:0] idx_q;
  reg mode_q;
  reg [XLEN-1:0] meta_q;
  // metadata as it stood before the current edge, to prove the alias leaves it alone
  always @(posedge clock_i) begin
    meta_q <= jvtc_rdata_o[2*XLEN-1:XLEN];
  end
  // the hart may change its inputs after acceptance
  always @(posedge clock_i) begin
    if (accept_o) begin
      idx_q <= instr_i[9:2];
      mode_q <= cap_mode_i;
    end
  end
  chk_csr_alias: assert property (jvt_we_i && !jvtc_we_i |=>
    jvt_rdata_o == $past(jvt_wdata_i) && jvt_rdata_o == jvtc_rdata_o[XLEN-1:0] &&
    jvtc_rdata_o[2*XLEN-1:XLEN] == meta_q) else $error("alias mismatch");
  chk_entry_addr: assert property (fetch_req_o |->
    fetch_addr_o == jvt_rdata_o + idx_q * (XLEN / 8)) else $error("entry address");
  chk_fault_quiet: assert property (fault_o |->
    !redirect_o && !link_we_o && !fetch_req_o) else $error("fault not quiet");
  chk_fault_code: assert property (fault_o |->
    fault_type_o == 4'h1 && fault_cause_o inside {[4'h1:4'h4]}) else $error("fault code");
  chk_debug_illegal: assert property (accept_o && debug_mode_i |=> illegal_o && !fault_o)
    else $error("debug not illegal");
  chk_link_index: assert property (redirect_o |-> link_we_o == (idx_q >= 8'h20))
    else $error("link index");
  chk_link_mode: assert property (link_we_o |-> redirect_o && link_cap_o == mode_q)
    else $error("link mode");
  chk_redirect_data: assert property (redirect_o |->
    $past(fetch_rvalid_i) && redirect_pc_o == $past(fetch_rdata_i)) else $error("target");
  chk_fetch_bound: assert property ($rose(fetch_req_o) |-> ##[2:20] redirect_o)
    else $error("no redirect");
endmodule // cap_table_jump_unit_chk
bind cap_table_jump_unit cap_table_jump_unit_chk #(.XLEN(XLEN)) chk_i (.*);

// [verif/tb_cap_table_jump_unit.sv]
// bench for the table-jump unit with a fetch path model
`timescale 1ns/1ns
module tb_cap_table_jump_unit;
  logic clock_i = 0, rst_i = 1, instr_valid_i = 0, cap_mode_i = 0, debug_mode_i = 0;
  logic jvtc_we_i = 0, jvtc_wtag_i = 0, jvt_we_i = 0, slow = 0, ctag = 0;
  logic [15:0] instr_i = 0;
  logic [31:0] pc_i = 0, jvt_wdata_i = 0, ca = 0, r;
  logic [63:0] jvtc_wdata_i = 0;
  logic [32:0] jvtc_wbase_i = 0, jvtc_wtop_i = 0, cb = 0, cp = 0;
  logic [1:0] cm = 0;
  wire ready_o, accept_o, jvtc_tag_o, fetch_req_o, fetch_gnt_i, fetch_rvalid_i, redirect_o;
  wire link_we_o, link_cap_o, illegal_o, fault_o, illegal2;
  wire [3:0] fault_type_o, fault_cause_o;
  wire [31:0] jvt_rdata_o, fetch_addr_o, fetch_rdata_i, redirect_pc_o, link_data_o, fault_addr_o;
  wire [63:0] jvtc_rdata_o;
  integer fails = 0, total_checks = 0, seed = 26626, k;
  cap_table_jump_unit DUT (.*);
  // second copy without the legacy extension: legacy forms must decode as illegal
  cap_table_jump_unit #(.HAS_LEGACY(0)) DUT2 (.clock_i, .rst_i, .instr_valid_i, .instr_i, .pc_i,
    .cap_mode_i, .debug_mode_i, .ready_o(), .accept_o(), .jvtc_we_i, .jvtc_wdata_i, .jvtc_wtag_i,
    .jvtc_wbase_i, .jvtc_wtop_i, .jvt_we_i, .jvt_wdata_i, .jvt_rdata_o(), .jvtc_rdata_o(),
    .jvtc_tag_o(), .fetch_req_o(), .fetch_addr_o(), .fetch_gnt_i(1'h1), .fetch_rvalid_i(1'h1),
    .fetch_rdata_i(32'h0), .redirect_o(), .redirect_pc_o(), .link_we_o(), .link_cap_o(),
    .link_data_o(), .illegal_o(illegal2), .fault_o(), .fault_type_o(), .fault_cause_o(),
    .fault_addr_o());
  fetch_partner far (.clock_i, .rst_i, .slow_i(slow), .req_i(fetch_req_o), .addr_i(fetch_addr_o),
    .gnt_o(fetch_gnt_i), .rvalid_o(fetch_rvalid_i), .rdata_o(fetch_rdata_i));
  initial forever #5 clock_i = ~clock_i;
  initial begin
    #100000;
    fails++;
    close_out;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input [95:0] s, input [95:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task close_out;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wcap(input [31:0] a, input [1:0] m, input t, input [32:0] b, input [32:0] p);
    @(negedge clock_i);
    jvtc_we_i = 1;
    jvtc_wdata_i = {30'h0, m, a};
    jvtc_wtag_i = t;
    jvtc_wbase_i = b;
    jvtc_wtop_i = p;
    @(negedge clock_i);
    jvtc_we_i = 0;
    {ca, cm, ctag, cb, cp} = {a, m, t, b, p};
    check({jvtc_tag_o, jvtc_rdata_o}, {t, 30'h0, m, a});
  endtask
  task jump(input [7:0] i, input m, input d);
    logic [3:0] e;
    logic [32:0] a;
    a = ca + i * 4;
    e = d ? 4'hF : !ctag ? 1 : cm[1] ? 2 : !cm[0] ? 3 : (a < cb || a + 4 > cp) ? 4 : 0;
    @(negedge clock_i);
    {instr_valid_i, cap_mode_i, debug_mode_i} = {1'b1, m, d};
    instr_i = {6'h28, i, 2'h2};
    pc_i = $random(seed);
    #1;
    check({ready_o, accept_o}, 2'h3);
    @(negedge clock_i);
    instr_valid_i = 0;
    cap_mode_i = ~m;
    check({ready_o, illegal2}, {e != 0, e == 15 || !m});
    for (k = 0; k < 40 && !(redirect_o | fault_o | illegal_o); k++) @(negedge clock_i);
    check({illegal_o, fault_o, redirect_o}, {e == 15, e != 0 && e != 15, e == 0});
    if (fault_o) begin
      check({fault_type_o, fault_cause_o}, {4'h1, e});
      check(fault_addr_o, a[31:0]);
    end
    if (e == 0) begin
      check({redirect_pc_o, link_we_o}, {a[15:0], 16'hC0DE, i >= 8'h20});
      if (link_we_o)
        check({link_cap_o, link_data_o}, {m, pc_i + 32'h2});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clock_i);
    rst_i = 0;
    jump(8'h03, 1, 0);
    wcap(32'h1000, 2'h3, 1, 33'h1000, 33'h1040);
    jump(8'h03, 0, 0);
    wcap(32'h1000, 2'h0, 1, 33'h1000, 33'h1040);
    jump(8'h03, 1, 0);
    wcap(32'h1000, 2'h1, 1, 33'h1000, 33'h1040);
    jump(8'h0F, 0, 0);
    jump(8'h10, 1, 0);
    jump(8'h00, 1, 1);
    @(negedge clock_i);
    jvt_we_i = 1;
    jvt_wdata_i = 32'h1004;
    @(negedge clock_i);
    jvt_we_i = 0;
    ca = 32'h1004;
    check(jvtc_rdata_o, {30'h1, 32'h1004});
    check({jvtc_tag_o, jvt_rdata_o}, {1'h1, 32'h1004});
    // alias moved the table, so entry 15 now starts at the top and lies wholly outside the bounds
    jump(8'h0F, 1, 0);
    jump(8'h0E, 0, 0);
    wcap(32'h2000, 2'h1, 1, 33'h2000, 33'h2400);
    jump(8'hFF, 1, 0);
    jump(8'h20, 0, 0);
    jump(8'h1F, 1, 0);
    repeat (60) begin
      r = $random(seed);
      if (r[1:0] == 0)
        wcap(r[15:0] & 16'hFFFC, r[18] ? 2'h1 : r[17:16], r[19] | r[20], r[15:0] & 16'hFFFC,
          (r[15:0] & 16'hFFFC) + {r[31:24], 2'h0});
      r = $random(seed);
      slow = r[21];
      jump(r[7:0], r[8], r[11:9] == 0);
    end
    close_out;
  end
endmodule // tb_cap_table_jump_unit
